// ### shared/tco_pkg.sv
// Purpose: Constants for the channel option controller
// Assumes: AXI4-Lite slave, 32-bit data
// Notes: Offsets are byte addresses
package tco_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    // Control field positions
    localparam int CTRL_W = 8;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_REGMODE = 2;
    localparam int CTRL_RXCORE = 3;
    localparam int CTRL_TXCORE = 4;
    localparam int CTRL_SERLPBK = 5;
    localparam int CTRL_REV_LSB = 6;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Event bits of status and mask
    localparam int EV_W = 3;
    localparam int EV_RXERR = 0;
    localparam int EV_TXERR = 1;
    localparam int EV_CALRST = 2;
    // Pin input bit positions
    localparam int PIN_W = 5;
    localparam int PIN_SIGDET = 0;
    localparam int PIN_CALSLP = 1;
    localparam int PIN_LPBK = 2;
    localparam int PIN_RXTICK = 3;
    localparam int PIN_TXTICK = 4;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Functional modes
    typedef enum logic [1:0] {
        MODE_BASIC = 2'b00,
        MODE_PCIE = 2'b01,
        MODE_DETLAT = 2'b10,
        MODE_OTHER = 2'b11
    } tco_mode_t;
    // Reverse loopback choice
    typedef enum logic [1:0] {
        REV_NONE = 2'b00,
        REV_PRE = 2'b01,
        REV_POST = 2'b10,
        REV_RSVD = 2'b11
    } tco_rev_t;
endpackage

// ### hdl/tco_channel_opts.sv
// Purpose: Optional control and status of one transceiver channel
// Assumes: One clock; pins and fabric ticks are asynchronous
// Notes: FIFO depth must be a power of two
`timescale 1ns/1ps

module tco_channel_opts
    import tco_pkg::*;
#(
    parameter int W = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    // Receive parallel side
    input wire logic rxDesValid,
    input wire logic [W-1:0] rxDesData,
    input wire logic rxRdReq,
    input wire logic rxCoreTick,
    output logic [W-1:0] rxData,
    output logic rxDataValid,
    output logic rxFifoErr,
    // Transmit parallel side
    input wire logic txValid,
    input wire logic [W-1:0] txData,
    input wire logic txCoreTick,
    input wire logic txSerReady,
    output logic [W-1:0] txSerData,
    output logic txSerValid,
    output logic txFifoErr,
    // Status and control pins
    input wire logic sigDetIn,
    input wire logic forceIdle,
    input wire logic calSleep,
    input wire logic lpbkCtl,
    output logic sigDetOut,
    output logic txElecIdle,
    output logic calEnable,
    output logic calPowerDown,
    output logic calRestart,
    output logic serialLoopOn,
    // Serial datapath
    input wire logic serTxBit,
    input wire logic rxPinBit,
    input wire logic cdrBit,
    output logic txLineBit,
    output logic desInBit,
    output logic txPathActive
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    // Whole module state
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [CTRL_W-1:0] ctrl;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] mask;
        logic awGot;
        logic wGot;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [1:0][DEPTH-1:0][W-1:0] mem;
        logic [1:0][PW-1:0] wp;
        logic [1:0][PW-1:0] rp;
        logic [1:0][CW-1:0] cnt;
        logic [1:0][W-1:0] fOut;
        logic [1:0] fOutV;
        logic [1:0] fErr;
        logic sigDet;
        logic txIdle;
        logic calPd;
        logic calRst;
        logic serLoop;
        logic txLine;
        logic desIn;
    } tco_st_t;

    tco_st_t q;
    tco_st_t d;
    tco_mode_t mode;
    tco_rev_t rev;
    logic bp;
    logic regEff;
    logic rxTick;
    logic txTick;
    logic [1:0] fWr;
    logic [1:0] fRd;
    logic [1:0][W-1:0] fIn;
    logic [EV_W-1:0] ev;

    // Decoded configuration
    assign mode = tco_mode_t'(q.ctrl[CTRL_MODE_LSB +: 2]);
    assign rev = tco_rev_t'(q.ctrl[CTRL_REV_LSB +: 2]);
    assign bp = (mode == MODE_BASIC) || (mode == MODE_PCIE);
    assign regEff = q.ctrl[CTRL_REGMODE] && (mode == MODE_DETLAT);

    // Fabric timing edges, from synchronized stages
    assign rxTick = q.s2[PIN_RXTICK] & ~q.s3[PIN_RXTICK];
    assign txTick = q.s2[PIN_TXTICK] & ~q.s3[PIN_TXTICK];

    // FIFO strobes, index 0 receive, 1 transmit
    assign fWr[0] = rxDesValid;
    assign fRd[0] = rxRdReq & (q.ctrl[CTRL_RXCORE] ? rxTick : 1'b1);
    assign fWr[1] = txValid & ~regEff & (q.ctrl[CTRL_TXCORE] ? txTick : 1'b1);
    assign fRd[1] = txSerReady & ~regEff;
    assign fIn[0] = rxDesData;
    assign fIn[1] = txData;

    // Bus handshakes
    assign awready = ~q.awGot;
    assign wready = ~q.wGot;
    assign bvalid = q.bValid;
    assign bresp = q.bResp;
    assign arready = ~q.rValid;
    assign rvalid = q.rValid;
    assign rdata = q.rData;
    assign rresp = q.rResp;
    assign irq = |(q.stat & q.mask);

    // Registered outputs; calEnable is tied high and txPathActive is decoded from ctrl
    assign rxData = q.fOut[0];
    assign rxDataValid = q.fOutV[0];
    assign rxFifoErr = q.fErr[0];
    assign txSerData = q.fOut[1];
    assign txSerValid = q.fOutV[1];
    assign txFifoErr = q.fErr[1];
    assign sigDetOut = q.sigDet;
    assign txElecIdle = q.txIdle;
    assign calEnable = 1'b1;
    assign calPowerDown = q.calPd;
    assign calRestart = q.calRst;
    assign serialLoopOn = q.serLoop;
    assign txLineBit = q.txLine;
    assign desInBit = q.desIn;
    assign txPathActive = (rev == REV_NONE);

    // Next state
    always_comb begin
        d = q;
        ev = '0;
        // Two-stage synchronizers plus edge stage
        d.s1 = {txCoreTick, rxCoreTick, lpbkCtl, calSleep, sigDetIn};
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Phase-compensation FIFOs
        for (int i = 0; i < 2; i++) begin
            d.fOutV[i] = 1'b0;
            d.fErr[i] = (fWr[i] && q.cnt[i] == FULL) || (fRd[i] && q.cnt[i] == '0);
            if (fWr[i] && q.cnt[i] != FULL) begin
                d.mem[i][q.wp[i]] = fIn[i];
                d.wp[i] = q.wp[i] + 1'b1;
            end
            if (fRd[i] && q.cnt[i] != '0) begin
                d.fOut[i] = q.mem[i][q.rp[i]];
                d.fOutV[i] = 1'b1;
                d.rp[i] = q.rp[i] + 1'b1;
            end
            d.cnt[i] = q.cnt[i] + CW'(fWr[i] && q.cnt[i] != FULL) - CW'(fRd[i] && q.cnt[i] != '0);
        end
        // Register mode bypasses the transmit FIFO, in detlat mode only
        if (regEff) begin
            d.fOut[1] = txData;
            d.fOutV[1] = txValid;
        end
        ev[EV_RXERR] = d.fErr[0];
        ev[EV_TXERR] = d.fErr[1];
        // Signal presence gated by mode
        d.sigDet = bp & q.s2[PIN_SIGDET];
        // Calibration sleep and restart
        d.calPd = q.s2[PIN_CALSLP];
        d.calRst = q.s3[PIN_CALSLP] & ~q.s2[PIN_CALSLP];
        ev[EV_CALRST] = d.calRst;
        // Serial loopback from synchronized control
        d.serLoop = q.ctrl[CTRL_SERLPBK] & q.s2[PIN_LPBK];
        d.desIn = q.serLoop ? serTxBit : rxPinBit;
        // Transmit buffer source; idle wins
        d.txIdle = bp & forceIdle;
        if (d.txIdle) begin
            d.txLine = 1'b0;
        end else if (rev == REV_PRE) begin
            d.txLine = rxPinBit;
        end else if (rev == REV_POST) begin
            d.txLine = cdrBit;
        end else begin
            d.txLine = serTxBit;
        end
        // Write channel capture
        if (awvalid && ~q.awGot) begin
            d.awGot = 1'b1;
            d.awAddr = awaddr;
        end
        if (wvalid && ~q.wGot) begin
            d.wGot = 1'b1;
            d.wData = wdata;
            d.wStrb = wstrb;
        end
        if (q.bValid && bready) begin
            d.bValid = 1'b0;
        end
        // Register write once both halves are held
        if (q.awGot && q.wGot && ~q.bValid) begin
            d.awGot = 1'b0;
            d.wGot = 1'b0;
            d.bValid = 1'b1;
            d.bResp = RESP_OKAY;
            if (q.awAddr == ADDR_CTRL) begin
                if (q.wStrb[0]) begin
                    d.ctrl = q.wData[CTRL_W-1:0];
                end
            end else if (q.awAddr == ADDR_STAT) begin
                if (q.wStrb[0]) begin
                    d.stat = q.stat & ~q.wData[EV_W-1:0];
                end
            end else if (q.awAddr == ADDR_MASK) begin
                if (q.wStrb[0]) begin
                    d.mask = q.wData[EV_W-1:0];
                end
            end else if (q.awAddr == ADDR_STATE) begin
                d.bResp = RESP_OKAY;
            end else begin
                d.bResp = RESP_SLVERR;
            end
        end
        // Sticky events; a set beats a same-cycle clear
        d.stat = d.stat | ev;
        // Read channel
        if (q.rValid && rready) begin
            d.rValid = 1'b0;
        end
        if (arvalid && ~q.rValid) begin
            d.rValid = 1'b1;
            d.rResp = RESP_OKAY;
            if (araddr == ADDR_CTRL) begin
                d.rData = 32'(q.ctrl);
            end else if (araddr == ADDR_STAT) begin
                d.rData = 32'(q.stat);
            end else if (araddr == ADDR_MASK) begin
                d.rData = 32'(q.mask);
            end else if (araddr == ADDR_STATE) begin
                d.rData = 32'({q.cnt[1], q.cnt[0], q.serLoop, q.calPd, q.sigDet});
            end else begin
                d.rData = 32'h0000_0000;
                d.rResp = RESP_SLVERR;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // Checks
    AST_SIGDET: assert property (@(posedge clk) disable iff (!rst_n)
        !bp |=> !sigDetOut) else $error("signal presence outside basic or pcie");
    AST_REGMODE: assert property (@(posedge clk) disable iff (!rst_n)
        (mode != MODE_DETLAT && txValid && !q.ctrl[CTRL_TXCORE] && q.cnt[1] == '0)
        |=> q.cnt[1] == CW'(1)) else $error("transmit FIFO bypassed outside detlat");
    AST_RXERR: assert property (@(posedge clk) disable iff (!rst_n)
        (rxDesValid && q.cnt[0] == FULL) |=> rxFifoErr) else $error("receive overflow not flagged");
    AST_TXERR: assert property (@(posedge clk) disable iff (!rst_n)
        (txSerReady && !regEff && q.cnt[1] == '0) |=> txFifoErr) else $error("transmit underrun not flagged");
    AST_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (bp && forceIdle) |=> (txElecIdle && !txLineBit)) else $error("forced idle ignored");
    AST_CALPD: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(calPowerDown) |-> $past(calSleep, 3)) else $error("power down without sleep");
    AST_CALRST: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(calPowerDown) |-> calRestart) else $error("no restart on sleep release");
    AST_LOOP: assert property (@(posedge clk) disable iff (!rst_n)
        serialLoopOn |=> (desInBit == $past(serTxBit))) else $error("loopback not routed");
    AST_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(serialLoopOn) |-> $past(lpbkCtl, 3)) else $error("loop control not synchronized");
    AST_REV: assert property (@(posedge clk) disable iff (!rst_n)
        (rev == REV_PRE && !(bp && forceIdle)) |-> (!txPathActive ##1 (txLineBit == $past(rxPinBit))))
        else $error("pre-recovery loop wrong");
endmodule

// ### tb/tco_fabric_model.sv
// Purpose: Fabric partner that sends transmit words, timing ticks and sleep
// Assumes: Same clock as the channel block
// Notes: Idle data is inverted so a stale word never looks fresh
`timescale 1ns/1ps
module tco_fabric_model (
    // Requests from the bench
    input wire logic clk,
    input wire logic req,
    input wire logic [31:0] din,
    input wire logic slp,
    // Pins towards the channel
    output logic txValid = 1'b0,
    output logic [31:0] txData = 32'h0,
    output logic tick,
    output logic calSleep = 1'b0
);
    logic [2:0] div_r = 3'h0;
    // One word per request cycle, shared sleep line
    always @(posedge clk) begin
        txValid <= req;
        txData <= req ? din : ~txData;
        calSleep <= slp;
        div_r <= div_r + 3'h1;
    end
    // Fabric timing at one eighth of the clock
    assign tick = div_r[2];
endmodule

// ### tb/transceiver_channel_options_tb.sv
// Purpose: Self-checking bench of the channel option block
// Assumes: 250 MHz clock, synchronous active-low reset
// Notes: Queues model both FIFOs; synchronized pins settle three edges late, forceIdle one
`timescale 1ns/1ps
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin badCount++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module transceiver_channel_options_tb;
    import tco_pkg::*;
    localparam int DEPTH = 8;
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic rxDesValid = 1'b0, rxRdReq = 1'b0, txSerReady = 1'b0, req = 1'b0, slp = 1'b0, sigDetIn = 1'b0;
    logic forceIdle = 1'b0, lpbkCtl = 1'b0, serTxBit = 1'b0, rxPinBit = 1'b0, cdrBit = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rxDesData = 32'h0, din = 32'h0, rdata, rxData, txData, txSerData, rd, mq;
    logic [1:0] bresp, rresp, rsp;
    logic awready, wready, bvalid, arready, rvalid, irq, tick, txValid, calSleep, rxDataValid, rxFifoErr;
    logic txSerValid, txFifoErr, sigDetOut, txElecIdle, calEnable, calPowerDown, calRestart, serialLoopOn;
    logic txLineBit, desInBit, txPathActive;
    logic [31:0] rxQ[$], txQ[$];
    int badCount = 0, checks = 0, cyc = 0, nRv = 0, nRe = 0, nTv = 0, nTe = 0, nCr = 0;
    tco_fabric_model i_tco_fabric_model (.clk, .req, .din, .slp, .txValid, .txData, .tick, .calSleep);
    tco_channel_opts #(.W(32), .DEPTH(DEPTH)) i_tco_channel_opts (.clk, .rst_n, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .irq, .rxDesValid, .rxDesData, .rxRdReq, .rxCoreTick(tick), .rxData,
        .rxDataValid, .rxFifoErr, .txValid, .txData, .txCoreTick(tick), .txSerReady, .txSerData, .txSerValid,
        .txFifoErr, .sigDetIn, .forceIdle, .calSleep, .lpbkCtl, .sigDetOut, .txElecIdle, .calEnable,
        .calPowerDown, .calRestart, .serialLoopOn, .serTxBit, .rxPinBit, .cdrBit, .txLineBit, .desInBit,
        .txPathActive);
    always #2 clk = ~clk;
    // Pulse counters, in-order data model and hang guard
    always @(posedge clk) begin
        cyc++;
        if (rxDataValid === 1'b1) begin
            nRv++;
            mq = rxQ.pop_front();
            `CK("rxData", mq, rxData)
        end
        if (txSerValid === 1'b1) begin
            nTv++;
            mq = txQ.pop_front();
            `CK("txSerData", mq, txSerData)
        end
        nRe += (rxFifoErr === 1'b1);
        nTe += (txFifoErr === 1'b1);
        nCr += (calRestart === 1'b1);
        if (cyc == 5000) begin
            badCount++;
            finalReport();
        end
    end
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic waitn(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    // Bus write, address and data offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit aw, w, b = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(negedge clk);
            aw = awready;
            w = wready;
            b = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
    endtask
    // Bus read into rd and rsp
    task automatic axr(input logic [7:0] a);
        bit ar, v = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!v) begin
            @(negedge clk);
            ar = arready;
            v = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (v) rready <= 1'b0;
        end
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h3d3c));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        waitn(0);
        `CK("calEnable", 1'b1, calEnable)
        `CK("txPathActive", 1'b1, txPathActive)
        axr(8'h10);
        `CK("unmapped", RESP_SLVERR, rsp)
        axw(8'h10, 32'hFF);
        `CK("wrUnmapped", RESP_SLVERR, rsp)
        sigDetIn <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            axw(ADDR_CTRL, m);
            waitn(4);
            `CK("sigDetOut", m < 2, sigDetOut)
        end
        axr(ADDR_CTRL);
        `CK("ctrlRead", 32'h3, rd)
        axw(ADDR_CTRL, 32'h0);
        for (int i = 0; i <= DEPTH; i++) begin
            rd = $urandom;
            rxDesValid <= 1'b1;
            rxDesData <= rd;
            if (i < DEPTH) rxQ.push_back(rd);
            @(posedge clk);
        end
        rxDesValid <= 1'b0;
        waitn(2);
        `CK("rxOverflow", 1, nRe)
        `CK("irqMasked", 1'b0, irq)
        axw(ADDR_MASK, 32'h7);
        `CK("wrOkay", RESP_OKAY, rsp)
        waitn(1);
        `CK("irqOn", 1'b1, irq)
        axw(ADDR_CTRL, 32'h8);
        rxRdReq <= 1'b1;
        repeat (16) @(posedge clk);
        rxRdReq <= 1'b0;
        waitn(3);
        `CK("tickReads", 2, nRv)
        axw(ADDR_CTRL, 32'h0);
        rxRdReq <= 1'b1;
        repeat (DEPTH - 1) @(posedge clk);
        rxRdReq <= 1'b0;
        waitn(3);
        `CK("rxReads", DEPTH, nRv)
        `CK("rxUnderrun", 2, nRe)
        axr(ADDR_STAT);
        `CK("statRx", 32'h1, rd)
        axw(ADDR_STAT, 32'h1);
        waitn(1);
        `CK("irqClear", 1'b0, irq)
        axw(ADDR_CTRL, 32'h0);
        for (int i = 0; i <= DEPTH; i++) begin
            rd = $urandom;
            din <= rd;
            req <= 1'b1;
            if (i < DEPTH) txQ.push_back(rd);
            @(posedge clk);
        end
        req <= 1'b0;
        repeat (3) @(posedge clk);
        txSerReady <= 1'b1;
        repeat (DEPTH + 1) @(posedge clk);
        txSerReady <= 1'b0;
        waitn(3);
        `CK("txReads", DEPTH, nTv)
        `CK("txErrors", 2, nTe)
        for (int m = 6; m >= 4; m -= 2) begin
            axw(ADDR_CTRL, m);
            rd = $urandom;
            din <= rd;
            req <= 1'b1;
            txQ.push_back(rd);
            @(posedge clk);
            req <= 1'b0;
            waitn(3);
            `CK("regMode", DEPTH + 1, nTv)
        end
        axw(ADDR_CTRL, 32'h0);
        txSerReady <= 1'b1;
        @(posedge clk);
        txSerReady <= 1'b0;
        waitn(2);
        `CK("fifoMode", DEPTH + 2, nTv)
        // Fabric write timing: 16 offered cycles admit two words
        axw(ADDR_CTRL, 32'h10);
        rd = $urandom;
        din <= rd;
        req <= 1'b1;
        repeat (16) @(posedge clk);
        req <= 1'b0;
        txQ.push_back(rd);
        txQ.push_back(rd);
        repeat (3) @(posedge clk);
        txSerReady <= 1'b1;
        repeat (2) @(posedge clk);
        txSerReady <= 1'b0;
        waitn(2);
        `CK("tickWrites", DEPTH + 4, nTv)
        for (int r = 1; r <= 2; r++) begin
            axw(ADDR_CTRL, r << 6);
            rxPinBit <= r[0];
            cdrBit <= r[1];
            waitn(2);
            `CK("revLoop", 1'b1, txLineBit)
            `CK("txActive", 1'b0, txPathActive)
        end
        @(posedge clk);
        forceIdle <= 1'b1;
        waitn(2);
        `CK("idleLine", 1'b0, txLineBit)
        `CK("idleFlag", 1'b1, txElecIdle)
        axw(ADDR_CTRL, 32'h20);
        forceIdle <= 1'b0;
        lpbkCtl <= 1'b1;
        serTxBit <= 1'b1;
        waitn(2);
        `CK("loopSync", 1'b0, serialLoopOn)
        waitn(2);
        `CK("loopOn", 1'b1, serialLoopOn)
        `CK("loopData", 1'b1, desInBit)
        @(posedge clk);
        lpbkCtl <= 1'b0;
        slp <= 1'b1;
        waitn(6);
        `CK("loopOff", 1'b0, desInBit)
        `CK("calDown", 1'b1, calPowerDown)
        @(posedge clk);
        slp <= 1'b0;
        waitn(6);
        `CK("calRestart", 1, nCr)
        `CK("calUp", 1'b0, calPowerDown)
        axr(ADDR_STAT);
        `CK("statCal", 32'h6, rd)
        axr(ADDR_STATE);
        `CK("stateRead", 32'h1, rd)
        finalReport();
    end
endmodule
